/* mmpc_decode.sv */
// Purpose: Turns classified pins into voltage, ceiling and bus address
// Assumes: Inputs are stable registered pin results
// Notes:   Purely combinational
`timescale 1ns/10ps
module mmpc_decode
  import mmpc_pkg::*;
(
  // Classified pins
  input  mmpc_pin_type [NUM_PINS-1:0] pins,
  // Decoded settings
  output mmpc_cfg_type                cfg
);

  function automatic logic [MV_W-1:0] strap_num(input mmpc_pin_type p);
    case (p.kind)
      MMPC_TIED_LOW:  strap_num = 16'h0000;
      MMPC_OPEN:      strap_num = 16'h0001;
      MMPC_TIED_HIGH: strap_num = 16'h0002;
      default:        strap_num = MV_W'(p.index);
    endcase
  endfunction

  function automatic logic [MV_W-1:0] tbl_idx(input logic [IDX_W-1:0] i);
    tbl_idx = (i > TBL_IDX_MAX) ? MV_W'(TBL_IDX_MAX) : MV_W'(i);
  endfunction

  mmpc_pin_type    fine;
  mmpc_pin_type    coarse;
  logic [MV_W-1:0] vout;
  logic [19:0]     ceil_prod;
  logic [ADDR_W-1:0] lo_sel;
  logic [ADDR_W-1:0] hi_sel;

  assign fine   = pins[PIN_VSEL_FIN];
  assign coarse = pins[PIN_VSEL_CRS];

  always_comb begin
    vout = VOUT_RST_MV;
    if (coarse.kind != MMPC_RESISTOR && fine.kind != MMPC_RESISTOR) begin
      vout = STRAP_MV[4'(3 * strap_num(coarse) + strap_num(fine))];
    end else if (coarse.kind == MMPC_RESISTOR && fine.kind == MMPC_TIED_LOW) begin
      if (coarse.index <= SGL_KNEE_IDX) begin
        vout = SGL_BASE_MV + MV_W'(SGL_FINE_MV * MV_W'(coarse.index));
      end else begin
        vout = SGL_KNEE_MV
             + MV_W'(SGL_COARSE_MV * MV_W'(coarse.index - SGL_KNEE_IDX));
      end
    end else if (coarse.kind == MMPC_RESISTOR && fine.kind == MMPC_RESISTOR) begin
      vout = MV_W'((tbl_idx(fine.index) + COARSE_WEIGHT * tbl_idx(coarse.index))
             * RES_STEP_MV);
    end
  end

  assign ceil_prod      = (20'(vout) * CEIL_NUM) / CEIL_DEN;
  assign lo_sel         = ADDR_W'(strap_num(pins[PIN_ADDR_LO]));
  assign hi_sel         = ADDR_W'(strap_num(pins[PIN_ADDR_HI]));
  assign cfg.vout_mv    = vout;
  assign cfg.ceiling_mv = MV_W'(ceil_prod);
  assign cfg.bus_addr   = ADDR_BASE + ADDR_W'(hi_sel * ADDR_HI_WEIGHT) + lo_sel;

endmodule

/* mmpc_loader.sv */
// Purpose: Samples multi-mode strap pins and holds the decoded configuration
// Assumes: Register port on the core clock; converter logic on the same clock
// Notes:   Pin levels are asynchronous and synchronised per pin
//
// Summary of operation
// - Each pin is classed as tied low, open, tied high or resistor.
// - Pins are sampled after reset and again on every restore command.
// - Strapped pins give three states; a pin pair selects one of nine.
// - Resistor codes are binned so only every fourth series value decodes.
// - A single resistor pin resolves to at most 31 codes.
// - The host may overwrite and read back the strapped output voltage.
// - Address and voltage ceiling come only from pins; others are writable.
// - Bus address is derived from the two address-select pins.
// - Voltage ceiling is ten percent above the pin-selected output voltage.
// - Duty command is capped at duty_max, 0xe6 after reset; the host may write any limit up to 0xff.
// - Two strapped voltage pins map onto nine fixed standard voltages.
// - Two resistors: coarse pin gives coarse step, fine pin 10 mV steps.
// - Fine pin tied low with coarse resistor uses the single-resistor table.
`timescale 1ns/10ps
module mmpc_loader
  import mmpc_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // Multi-mode pin sensing
  input  wire logic [NUM_PINS-1:0]           pin_level,
  output logic      [NUM_PINS-1:0]           pull_up_en,
  output logic      [NUM_PINS-1:0]           pull_dn_en,
  // Resistance converter
  output logic                               adc_start,
  input  wire logic                          adc_done,
  input  wire logic [NUM_PINS-1:0][ADC_W-1:0] adc_code,
  // Register port
  input  wire logic [REG_AW-1:0]             reg_addr,
  input  wire logic [DATA_W-1:0]             reg_wdata,
  input  wire logic                          reg_write,
  input  wire logic                          reg_read,
  output logic      [DATA_W-1:0]             reg_rdata,
  // PWM duty path
  input  wire logic [DUTY_W-1:0]             duty_request,
  output logic      [DUTY_W-1:0]             duty_limited,
  // Configuration outputs
  output logic      [ADDR_W-1:0]             bus_addr,
  output logic      [MV_W-1:0]               vout_setting,
  output logic      [MV_W-1:0]               output_voltage_ceiling,
  output logic                               config_valid,
  output logic                               sampling_busy
);

  mmpc_seq_type                state;
  mmpc_seq_type                next_state;
  logic [CNT_W-1:0]            settle_cnt;
  logic                        settle_done;
  logic                        start_pending;
  logic                        restore_cmd;
  logic                        adc_issued;
  logic                        capture_up;
  logic                        capture_dn;
  logic                        capture_adc;
  mmpc_pin_type [NUM_PINS-1:0] pins;
  mmpc_cfg_type                decoded;
  logic [DUTY_W-1:0]           duty_max;
  logic [DATA_W-1:0]           next_rdata;

  // Restore command from the register port
  assign restore_cmd = reg_write && (reg_addr == REG_CTRL) && reg_wdata[CTRL_RESTORE_BIT];

  // Sampling request: set after reset and on restore
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_pending <= 1'b1;
    end else if (restore_cmd) begin
      start_pending <= 1'b1;
    end else if (state == MMPC_S_IDLE) begin
      start_pending <= 1'b0;
    end
  end

  // Settling counter
  assign settle_done = (settle_cnt == CNT_W'(SETTLE_CYCLES - 1));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= '0;
    end else if (state != next_state) begin
      settle_cnt <= '0;
    end else if ((state == MMPC_S_PULL_UP || state == MMPC_S_PULL_DN) && !settle_done) begin
      settle_cnt <= settle_cnt + CNT_W'(1);
    end
  end

  // Sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      MMPC_S_IDLE: begin
        if (start_pending) next_state = MMPC_S_PULL_UP;
      end
      MMPC_S_PULL_UP: begin
        if (settle_done) next_state = MMPC_S_PULL_DN;
      end
      MMPC_S_PULL_DN: begin
        if (settle_done) next_state = MMPC_S_CONVERT;
      end
      MMPC_S_CONVERT: begin
        if (adc_issued && adc_done) next_state = MMPC_S_APPLY;
      end
      MMPC_S_APPLY: begin
        next_state = MMPC_S_IDLE;
      end
      default: begin
        next_state = MMPC_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= MMPC_S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture strobes
  assign capture_up  = (state == MMPC_S_PULL_UP) && settle_done;
  assign capture_dn  = (state == MMPC_S_PULL_DN) && settle_done;
  assign capture_adc = (state == MMPC_S_CONVERT) && adc_issued && adc_done;

  // Weak pull drive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_up_en <= '0;
      pull_dn_en <= '0;
    end else begin
      pull_up_en <= {NUM_PINS{next_state == MMPC_S_PULL_UP}};
      pull_dn_en <= {NUM_PINS{next_state == MMPC_S_PULL_DN}};
    end
  end

  // Converter start, one pulse per sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_start  <= 1'b0;
      adc_issued <= 1'b0;
    end else begin
      adc_start <= (state == MMPC_S_PULL_DN) && settle_done;
      if (state == MMPC_S_CONVERT) begin
        adc_issued <= 1'b1;
      end else begin
        adc_issued <= 1'b0;
      end
    end
  end

  // Per-pin classification
  generate
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
      mmpc_pin_sense u_sense (
        .clk         (clk),
        .rst_n       (rst_n),
        .pin_level   (pin_level[p]),
        .adc_code    (adc_code[p]),
        .capture_up  (capture_up),
        .capture_dn  (capture_dn),
        .capture_adc (capture_adc),
        .result      (pins[p])
      );
    end
  endgenerate

  mmpc_decode u_decode (
    .pins (pins),
    .cfg  (decoded)
  );

  // Pin-only settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_addr               <= ADDR_BASE;
      output_voltage_ceiling <= VOUT_RST_MV;
    end else if (state == MMPC_S_APPLY) begin
      bus_addr               <= decoded.bus_addr;
      output_voltage_ceiling <= decoded.ceiling_mv;
    end
  end

  // Output voltage setting: pins load it, host may overwrite
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vout_setting <= VOUT_RST_MV;
    end else if (state == MMPC_S_APPLY) begin
      vout_setting <= decoded.vout_mv;
    end else if (reg_write && reg_addr == REG_VOUT) begin
      vout_setting <= reg_wdata;
    end
  end

  // Duty limit setting
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_max <= DUTY_MAX_RST;
    end else if (reg_write && reg_addr == REG_DUTY_MAX) begin
      duty_max <= reg_wdata[DUTY_W-1:0];
    end
  end

  // Duty cap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_limited <= '0;
    end else if (duty_request > duty_max) begin
      duty_limited <= duty_max;
    end else begin
      duty_limited <= duty_request;
    end
  end

  // Status flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_valid  <= 1'b0;
      sampling_busy <= 1'b0;
    end else begin
      if (state == MMPC_S_APPLY) config_valid <= 1'b1;
      sampling_busy <= (next_state != MMPC_S_IDLE);
    end
  end

  // Read multiplexer
  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      REG_STATUS: begin
        next_rdata[7:0]            = {pins[3].kind, pins[2].kind, pins[1].kind, pins[0].kind};
        next_rdata[STAT_BUSY_BIT]  = sampling_busy;
        next_rdata[STAT_VALID_BIT] = config_valid;
      end
      REG_VOUT: begin
        next_rdata = vout_setting;
      end
      REG_ADDR: begin
        next_rdata[ADDR_W-1:0] = bus_addr;
      end
      REG_CEILING: begin
        next_rdata = output_voltage_ceiling;
      end
      REG_CTRL: begin
        next_rdata = '0;
      end
      REG_DUTY_MAX: begin
        next_rdata[DUTY_W-1:0] = duty_max;
      end
      REG_IDX_LO: begin
        next_rdata[12:0] = {pins[1].index, 3'h0, pins[0].index};
      end
      REG_IDX_HI: begin
        next_rdata[12:0] = {pins[3].index, 3'h0, pins[2].index};
      end
      default: begin
        next_rdata = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule

/* mmpc_loader_asserts.sv */
// Purpose: Port assertions for the pin configuration loader
// Assumes: One clock domain, reset active low
// Notes:   Bound to every loader instance
`timescale 1ns/10ps
module mmpc_loader_chk
  import mmpc_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rst_n,
  // Watched ports
  input wire logic [NUM_PINS-1:0] pull_up_en,
  input wire logic [NUM_PINS-1:0] pull_dn_en,
  input wire logic                adc_start,
  input wire logic                adc_done,
  input wire logic                reg_read,
  input wire logic [DATA_W-1:0]   reg_rdata,
  input wire logic [DUTY_W-1:0]   duty_request,
  input wire logic [DUTY_W-1:0]   duty_limited,
  input wire logic [ADDR_W-1:0]   bus_addr,
  input wire logic [MV_W-1:0]     vout_setting,
  input wire logic [MV_W-1:0]     output_voltage_ceiling,
  input wire logic                config_valid,
  input wire logic                sampling_busy
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_pulls_busy: assert property (|pull_up_en || |pull_dn_en |-> sampling_busy)
    else $error("pull enabled while idle");
  chk_pulls_apart: assert property (!(|pull_up_en && |pull_dn_en))
    else $error("both pulls enabled");
  chk_up_then_down: assert property ($fell(pull_up_en[0]) |-> pull_dn_en[0])
    else $error("pull-down phase missing");
  chk_start_pulse: assert property (adc_start |=> !adc_start)
    else $error("conversion start longer than one cycle");
  chk_ceiling_ratio: assert property ($changed(output_voltage_ceiling) |->
    output_voltage_ceiling == 16'((20'(vout_setting) * 20'h0000b) / 20'h0000a))
    else $error("ceiling not ten percent above voltage");
  chk_addr_held: assert property ($changed(bus_addr) |-> $past(sampling_busy))
    else $error("bus address changed outside sampling");
  chk_duty_cap: assert property (1'b1 |=> duty_limited <= $past(duty_request))
    else $error("duty above request");
  chk_rdata_idle: assert property (!reg_read |=> reg_rdata == '0)
    else $error("read data without read");
  chk_valid_sticky: assert property (config_valid |=> config_valid)
    else $error("config valid dropped");
  chk_valid_apply: assert property ($rose(config_valid) |-> $past(adc_done, 2))
    else $error("config valid without conversion");

  cov_valid: cover property ($rose(config_valid));
  cov_start: cover property (adc_start);
  cov_read: cover property (reg_read ##1 reg_rdata != '0);
endmodule

bind mmpc_loader mmpc_loader_chk u_chk (.clk(clk), .rst_n(rst_n), .pull_up_en(pull_up_en),
  .pull_dn_en(pull_dn_en), .adc_start(adc_start), .adc_done(adc_done), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .duty_request(duty_request), .duty_limited(duty_limited),
  .bus_addr(bus_addr), .vout_setting(vout_setting),
  .output_voltage_ceiling(output_voltage_ceiling), .config_valid(config_valid),
  .sampling_busy(sampling_busy));

/* mmpc_pin_network.sv */
// Purpose: Behavioural pins, straps, resistors and converter
// Assumes: Converter on the loader clock
// Notes:   Slow mode stretches the conversion
`timescale 1ns/10ps
module mmpc_pin_network
  import mmpc_pkg::*;
(
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // Set-up chosen by the bench
  input  mmpc_pin_type [NUM_PINS-1:0]         pin_cfg,
  input  wire logic                           slow,
  // Loader side
  input  wire logic [NUM_PINS-1:0]            pull_up_en,
  input  wire logic [NUM_PINS-1:0]            pull_dn_en,
  input  wire logic                           adc_start,
  output logic      [NUM_PINS-1:0]            pin_level,
  output logic                                adc_done,
  output logic      [NUM_PINS-1:0][ADC_W-1:0] adc_code
);
  logic                           toggle;
  logic [7:0]                     wait_cnt;
  logic [NUM_PINS-1:0][ADC_W-1:0] code;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle <= 1'b0;
    end else begin
      toggle <= ~toggle;
    end
  end

  // Pin level and resistance per connection kind
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_level[p] = 1'b0;
      code[p] = 8'hff;
      if (pin_cfg[p].kind == MMPC_TIED_HIGH) pin_level[p] = 1'b1;
      if (pin_cfg[p].kind == MMPC_OPEN) begin
        pin_level[p] = pull_up_en[p] | (~pull_dn_en[p] & toggle);
      end
      if (pin_cfg[p].kind == MMPC_TIED_LOW) code[p] = 8'h02;
      if (pin_cfg[p].kind == MMPC_RESISTOR) code[p] = 8'h08 + {pin_cfg[p].index, 3'b000};
    end
    adc_code = adc_done ? code : ~code;
  end

  // Conversion delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 8'h00;
      adc_done <= 1'b0;
    end else begin
      adc_done <= (wait_cnt == 8'h01);
      if (adc_start) wait_cnt <= slow ? 8'h28 : 8'h01;
      else if (wait_cnt != 8'h00) wait_cnt <= wait_cnt - 8'h01;
    end
  end
endmodule

/* mmpc_pin_sense.sv */
// Purpose: Synchronises one multi-mode pin and classifies its connection
// Assumes: Capture strobes come from the sequencer on the same clock
// Notes:   Resistor code is 8 LSB per used resistor step
`timescale 1ns/10ps
module mmpc_pin_sense
  import mmpc_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Pin side
  input  wire logic             pin_level,
  input  wire logic [ADC_W-1:0] adc_code,
  // Sequencer strobes
  input  wire logic             capture_up,
  input  wire logic             capture_dn,
  input  wire logic             capture_adc,
  // Result
  output mmpc_pin_type          result
);

  logic             sync_a;
  logic             sync_b;
  logic             up_high;
  logic             dn_high;
  logic [ADC_W:0]   offset;
  logic [IDX_W-1:0] next_index;
  mmpc_kind_type    next_kind;

  // Two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= pin_level;
      sync_b <= sync_a;
    end
  end

  // Levels under each weak pull
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_high <= 1'b0;
      dn_high <= 1'b0;
    end else begin
      if (capture_up) up_high <= sync_b;
      if (capture_dn) dn_high <= sync_b;
    end
  end

  // Kind and resistor index
  always_comb begin
    offset     = {1'b0, adc_code} - {1'b0, ADC_RES_BASE} + ADC_HALF_BIN;
    next_index = '0;
    if (dn_high) begin
      next_kind = MMPC_TIED_HIGH;
    end else if (up_high) begin
      next_kind = MMPC_OPEN;
    end else if (adc_code <= ADC_LOW_MAX) begin
      next_kind = MMPC_TIED_LOW;
    end else begin
      next_kind = MMPC_RESISTOR;
      if (adc_code < ADC_RES_BASE) begin
        next_index = '0;
      end else if ((offset >> BIN_SHIFT) > 9'(RES_IDX_MAX)) begin
        next_index = RES_IDX_MAX;
      end else begin
        next_index = IDX_W'(offset >> BIN_SHIFT);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '{kind: MMPC_OPEN, index: '0};
    end else if (capture_adc) begin
      result <= '{kind: next_kind, index: next_index};
    end
  end

endmodule

/* mmpc_pkg.sv */
// Purpose: Shared constants and types for the multi-mode pin configuration loader
// Assumes: 125 MHz clock; one clock domain
// Notes:   Widths and counts are fixed
package mmpc_pkg;

  // Connection kinds of a multi-mode pin
  typedef enum logic [1:0] {
    MMPC_TIED_LOW,
    MMPC_OPEN,
    MMPC_TIED_HIGH,
    MMPC_RESISTOR
  } mmpc_kind_type;

  // Sampling sequencer states
  typedef enum logic [2:0] {
    MMPC_S_IDLE,
    MMPC_S_PULL_UP,
    MMPC_S_PULL_DN,
    MMPC_S_CONVERT,
    MMPC_S_APPLY
  } mmpc_seq_type;

  localparam int NUM_PINS     = 4;
  localparam int PIN_ADDR_LO  = 0;
  localparam int PIN_ADDR_HI  = 1;
  localparam int PIN_VSEL_FIN = 2;
  localparam int PIN_VSEL_CRS = 3;
  localparam int ADC_W        = 8;
  localparam int IDX_W        = 5;
  localparam int MV_W         = 16;
  localparam int ADDR_W       = 7;
  localparam int DATA_W       = 16;
  localparam int REG_AW       = 8;
  localparam int DUTY_W       = 8;

  typedef struct packed {
    mmpc_kind_type          kind;
    logic [IDX_W-1:0]       index;
  } mmpc_pin_type;

  typedef struct packed {
    logic [MV_W-1:0]        vout_mv;
    logic [MV_W-1:0]        ceiling_mv;
    logic [ADDR_W-1:0]      bus_addr;
  } mmpc_cfg_type;

  // Settling time of the weak pulls
  localparam int CLK_PERIOD_NS = 8;
  localparam int SETTLE_NS     = 10000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 12;

  // Resistance code to index conversion
  localparam logic [ADC_W-1:0] ADC_LOW_MAX  = 8'h04;
  localparam logic [ADC_W-1:0] ADC_RES_BASE = 8'h08;
  localparam logic [ADC_W:0]   ADC_HALF_BIN = 9'h004;
  localparam int               BIN_SHIFT    = 3;
  localparam logic [IDX_W-1:0] RES_IDX_MAX  = 5'h1e;
  localparam logic [IDX_W-1:0] TBL_IDX_MAX  = 5'h18;

  // Output voltage tables in millivolts
  localparam logic [MV_W-1:0] STRAP_MV [0:8] = '{
    16'h0258, 16'h0320, 16'h03e8,
    16'h04b0, 16'h05dc, 16'h0708,
    16'h09c4, 16'h0ce4, 16'h1388
  };
  localparam logic [MV_W-1:0]  SGL_BASE_MV   = 16'h0258;
  localparam logic [MV_W-1:0]  SGL_FINE_MV   = 16'h0032;
  localparam logic [IDX_W-1:0] SGL_KNEE_IDX  = 5'h0e;
  localparam logic [MV_W-1:0]  SGL_KNEE_MV   = 16'h0514;
  localparam logic [MV_W-1:0]  SGL_COARSE_MV = 16'h0064;
  localparam logic [MV_W-1:0]  COARSE_WEIGHT = 16'h0019;
  localparam logic [MV_W-1:0]  RES_STEP_MV   = 16'h000a;
  localparam logic [MV_W-1:0]  VOUT_RST_MV   = 16'h0258;
  localparam logic [19:0]      CEIL_NUM      = 20'h0000b;
  localparam logic [19:0]      CEIL_DEN      = 20'h0000a;

  // Bus address derivation
  localparam logic [ADDR_W-1:0] ADDR_BASE      = 7'h20;
  localparam logic [ADDR_W-1:0] ADDR_HI_WEIGHT = 7'h03;

  // Register offsets
  localparam logic [REG_AW-1:0] REG_STATUS   = 8'h00;
  localparam logic [REG_AW-1:0] REG_VOUT     = 8'h04;
  localparam logic [REG_AW-1:0] REG_ADDR     = 8'h08;
  localparam logic [REG_AW-1:0] REG_CEILING  = 8'h0c;
  localparam logic [REG_AW-1:0] REG_CTRL     = 8'h10;
  localparam logic [REG_AW-1:0] REG_DUTY_MAX = 8'h14;
  localparam logic [REG_AW-1:0] REG_IDX_LO   = 8'h18;
  localparam logic [REG_AW-1:0] REG_IDX_HI   = 8'h1c;

  // Field positions and reset values
  localparam int                CTRL_RESTORE_BIT = 0;
  localparam int                STAT_BUSY_BIT    = 8;
  localparam int                STAT_VALID_BIT   = 9;
  localparam logic [DUTY_W-1:0] DUTY_MAX_RST     = 8'he6;

endpackage

/* multimode_pin_config_loader_tb_top.sv */
// Purpose: Self-checking bench for the pin configuration loader
// Assumes: 125 MHz clock, reset held 16 cycles
// Notes:   Expected values come from an integer model
`timescale 1ns/10ps
module multimode_pin_config_loader_tb_top;
  import mmpc_pkg::*;
  logic                           clk, rst_n, reg_write, reg_read, slow;
  logic                           adc_start, adc_done, config_valid, sampling_busy;
  logic [NUM_PINS-1:0]            pin_level, pull_up_en, pull_dn_en;
  logic [NUM_PINS-1:0][ADC_W-1:0] adc_code;
  logic [REG_AW-1:0]              reg_addr;
  logic [DATA_W-1:0]              reg_wdata, reg_rdata, rd_val, v;
  logic [DUTY_W-1:0]              duty_request, duty_limited;
  logic [ADDR_W-1:0]              bus_addr;
  logic [MV_W-1:0]                vout_setting, output_voltage_ceiling;
  mmpc_pin_type [NUM_PINS-1:0]    pin_cfg;
  int                             fail_count, checks, cycles, exp_addr, exp_mv, i2, i3;
  int                             strap_mv[9] = '{600, 800, 1000, 1200, 1500, 1800,
                                                  2500, 3300, 5000};

  mmpc_loader u_dut (.clk(clk), .rst_n(rst_n), .pin_level(pin_level), .pull_up_en(pull_up_en),
    .pull_dn_en(pull_dn_en), .adc_start(adc_start), .adc_done(adc_done), .adc_code(adc_code),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .duty_request(duty_request), .duty_limited(duty_limited),
    .bus_addr(bus_addr), .vout_setting(vout_setting),
    .output_voltage_ceiling(output_voltage_ceiling), .config_valid(config_valid),
    .sampling_busy(sampling_busy));

  mmpc_pin_network u_pins (.clk(clk), .rst_n(rst_n), .pin_cfg(pin_cfg), .slow(slow),
    .pull_up_en(pull_up_en), .pull_dn_en(pull_dn_en), .adc_start(adc_start),
    .pin_level(pin_level), .adc_done(adc_done), .adc_code(adc_code));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      fail_count++;
      $display("unexpected at %0t: run too long", $time);
      results();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [REG_AW-1:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    rd_val = reg_rdata;
  endtask

  task automatic run_sampling();
    int n;
    n = 0;
    while (sampling_busy !== 1'b1 && n < 50) begin
      @(posedge clk) #1;
      n++;
    end
    while (sampling_busy !== 1'b0 && n < 4000) begin
      @(posedge clk) #1;
      n++;
    end
    if (n >= 4000) chk(16'h0001, 16'h0000);
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic int sel(mmpc_pin_type p);
    return p.kind == MMPC_RESISTOR ? int'(p.index) : int'(p.kind);
  endfunction

  function automatic int ridx(mmpc_pin_type p);
    return p.kind == MMPC_RESISTOR ? int'(p.index) : 0;
  endfunction

  task automatic set_cfg(input int k);
    for (int p = 0; p < NUM_PINS; p++) begin
      pin_cfg[p].kind = mmpc_kind_type'($urandom_range(3, 0));
      pin_cfg[p].index = 5'($urandom_range(30, 0));
    end
    if (k < 9) begin
      pin_cfg[3].kind = mmpc_kind_type'(k / 3);
      pin_cfg[2].kind = mmpc_kind_type'(k % 3);
    end
    if (k == 9) pin_cfg[2].kind = MMPC_TIED_LOW;
    if (k == 9) pin_cfg[3].kind = MMPC_RESISTOR;
    if (k == 10) pin_cfg[2].kind = MMPC_RESISTOR;
    if (k == 10) pin_cfg[3].kind = MMPC_RESISTOR;
  endtask

  task automatic verify();
    i2 = sel(pin_cfg[2]) > 24 ? 24 : sel(pin_cfg[2]);
    i3 = sel(pin_cfg[3]);
    exp_addr = (32 + 3 * sel(pin_cfg[1]) + sel(pin_cfg[0])) % 128;
    exp_mv = 600;
    if (pin_cfg[2].kind != MMPC_RESISTOR && pin_cfg[3].kind != MMPC_RESISTOR)
      exp_mv = strap_mv[3 * i3 + i2];
    if (pin_cfg[2].kind == MMPC_TIED_LOW && pin_cfg[3].kind == MMPC_RESISTOR)
      exp_mv = i3 <= 14 ? 600 + 50 * i3 : 1300 + 100 * (i3 - 14);
    if (pin_cfg[2].kind == MMPC_RESISTOR && pin_cfg[3].kind == MMPC_RESISTOR)
      exp_mv = (i2 + 25 * (i3 > 24 ? 24 : i3)) * 10;
    chk(16'(bus_addr), 16'(exp_addr));
    chk(vout_setting, 16'(exp_mv));
    chk(output_voltage_ceiling, 16'(exp_mv * 11 / 10));
    rd(REG_STATUS);
    chk(rd_val, {6'h02, pin_cfg[3].kind, pin_cfg[2].kind,
                 pin_cfg[1].kind, pin_cfg[0].kind});
    rd(REG_VOUT);
    chk(rd_val, 16'(exp_mv));
    rd(REG_ADDR);
    chk(rd_val, 16'(exp_addr));
    rd(REG_IDX_LO);
    chk(rd_val, 16'(ridx(pin_cfg[1]) * 256 + ridx(pin_cfg[0])));
    rd(REG_IDX_HI);
    chk(rd_val, 16'(ridx(pin_cfg[3]) * 256 + ridx(pin_cfg[2])));
  endtask

  initial begin
    rst_n = 1'b0;
    {reg_write, reg_read, slow, reg_addr, reg_wdata, duty_request} = '0;
    fail_count = 0;
    checks = 0;
    cycles = 0;
    void'($urandom(35));
    set_cfg(0);
    repeat (16) @(posedge clk);
    chk(vout_setting, 16'h0258);
    chk(16'({config_valid, bus_addr}), 16'h0020);
    rst_n <= 1'b1;
    run_sampling();
    verify();
    for (int k = 1; k < 16; k++) begin
      set_cfg(k);
      slow <= k[0];
      wr(REG_CTRL, 16'h0001);
      run_sampling();
      verify();
    end
    rd(REG_DUTY_MAX);
    chk(rd_val, 16'h00e6);
    rd(REG_CTRL);
    chk(rd_val, 16'h0000);
    rd(8'h20);
    chk(rd_val, 16'h0000);
    v = 16'(600 + $urandom_range(4400, 0));
    wr(REG_VOUT, v);
    rd(REG_VOUT);
    chk(rd_val, v);
    chk(vout_setting, v);
    wr(REG_ADDR, 16'h0055);
    wr(REG_CEILING, 16'hffff);
    rd(REG_ADDR);
    chk(rd_val, 16'(exp_addr));
    chk(output_voltage_ceiling, 16'(exp_mv * 11 / 10));
    wr(REG_DUTY_MAX, 16'h0080);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      duty_request <= (k == 0) ? 8'h81 : 8'($urandom);
      @(posedge clk);
      #1;
      chk(16'(duty_limited), 16'(duty_request > 8'h80 ? 8'h80 : duty_request));
    end
    wr(REG_CTRL, 16'h0001);
    run_sampling();
    verify();
    results();
  end
endmodule
